// ===== src/dsp_output_stage.sv
`timescale 1ns/1ps
module result_fifo #(
    parameter int WIDTH = 144,
    parameter int DEPTH = 32
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data,
    output logic [$clog2(DEPTH):0] level
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_q, rd_q;
    logic [AW:0] cnt_q;
    logic push, pop;
    assign in_ready = (cnt_q != DEPTH[AW:0]);
    assign out_valid = (cnt_q != '0);
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign out_data = mem[rd_q];
    assign level = cnt_q;
    always_ff @(posedge aclk) begin
        if (push) begin
            mem[wr_q] <= in_data;
        end
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
        end else begin
            if (push) wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
            if (pop) rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
            cnt_q <= cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
        end
    end
    // A ready that stayed high when full would let the level run past the depth
    full_block_a: assert property (@(posedge aclk) disable iff (!aresetn)
        !(cnt_q > DEPTH[AW:0])) else $error("fifo level above depth");
endmodule

module dsp_output_stage
    import dsp_out_pkg::*;
#(
    parameter int DEPTH = dsp_out_pkg::FIFO_DEPTH
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write
    input wire logic [dsp_out_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read
    input wire logic [dsp_out_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Register control sets
    input wire logic [3:0] reg_tick,
    input wire logic [3:0] reg_clr,
    input wire logic [3:0] reg_ena,
    // Operand stream from the multiplier inputs
    input wire logic op_valid,
    output logic op_ready,
    input wire logic [dsp_out_pkg::LANES-1:0][dsp_out_pkg::OP_W-1:0] op_a,
    input wire logic [dsp_out_pkg::LANES-1:0][dsp_out_pkg::OP_W-1:0] op_b,
    // Result stream to the logic array
    output logic res_valid,
    input wire logic res_ready,
    output logic [dsp_out_pkg::RES_W-1:0] res_data
);
    import dsp_out_pkg::*;

    logic [CTRL_W-1:0] ctrl_q;
    logic acc_clr;
    logic [ADDR_W-1:0] aw_addr_q;
    logic aw_have_q, w_have_q;
    logic [31:0] w_data_q;
    logic [3:0] w_strb_q;
    logic do_write;
    logic [31:0] rd_word;
    logic [31:0] count_q;
    mode_t mode;
    wid_t wid;
    logic reg_on, sub, tick, clr, ena;
    logic signed [35:0] p18 [LANES];
    logic signed [17:0] p9 [2*LANES];
    logic signed [71:0] p36;
    logic signed [36:0] s01, s23;
    logic signed [37:0] s4;
    logic signed [ACC_W-1:0] acc_q, acc_d;
    logic [RES_W-1:0] mux_v;
    logic [RES_W-1:0] out_q;
    logic pend_q;
    logic take;
    logic f_in_valid, f_in_ready;
    logic [RES_W-1:0] f_in_data;
    logic [$clog2(DEPTH):0] f_level;

    function automatic logic [RES_W-1:0] sext(input logic signed [71:0] v);
        sext = RES_W'(v);
        sext[RES_W-1:72] = {(RES_W-72){v[71]}};
    endfunction

    function automatic logic pick(input logic [3:0] set, input logic [1:0] sel);
        pick = set[sel];
    endfunction

    // Single mode field, so one block never runs two modes
    assign mode = mode_t'(ctrl_q[MODE_LSB +: 2]);
    assign wid = wid_t'(ctrl_q[WID_LSB +: 2]);
    assign reg_on = ctrl_q[REG_ON_BIT];
    assign sub = ctrl_q[SUB_BIT];
    assign tick = pick(reg_tick, ctrl_q[CLK_SEL_LSB +: 2]);
    assign clr = pick(reg_clr, ctrl_q[CLR_SEL_LSB +: 2]);
    assign ena = pick(reg_ena, ctrl_q[ENA_SEL_LSB +: 2]);

    // Register bus: write address and data may arrive in either order
    assign s_axi_awready = !aw_have_q && !s_axi_bvalid;
    assign s_axi_wready = !w_have_q && !s_axi_bvalid;
    assign do_write = aw_have_q && w_have_q && !s_axi_bvalid;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            aw_addr_q <= '0;
            w_data_q <= '0;
            w_strb_q <= '0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OK;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_have_q <= 1'b1;
                aw_addr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_have_q <= 1'b1;
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
            end
            if (do_write) begin
                aw_have_q <= 1'b0;
                w_have_q <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (aw_addr_q == CTRL_OFF) ? RESP_OK : RESP_ERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    assign acc_clr = do_write && aw_addr_q == CTRL_OFF && w_strb_q[1] && w_data_q[ACC_CLR_BIT];
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_q <= CTRL_RST[CTRL_W-1:0];
        end else if (do_write && aw_addr_q == CTRL_OFF) begin
            if (w_strb_q[0]) ctrl_q[7:0] <= w_data_q[7:0];
            if (w_strb_q[1]) ctrl_q[CTRL_W-1:8] <= w_data_q[CTRL_W-1:8];
        end
    end

    always_comb begin
        unique case (s_axi_araddr)
            CTRL_OFF: rd_word = {{(32-CTRL_W){1'b0}}, ctrl_q};
            STATUS_OFF: rd_word = {{(31-$clog2(DEPTH)-1){1'b0}}, pend_q, f_level};
            COUNT_OFF: rd_word = count_q;
            default: rd_word = 32'h0000_0000;
        endcase
    end
    assign s_axi_arready = !s_axi_rvalid;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= RESP_OK;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_word;
            s_axi_rresp <= (s_axi_araddr == CTRL_OFF || s_axi_araddr == STATUS_OFF ||
                            s_axi_araddr == COUNT_OFF) ? RESP_OK : RESP_ERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // Products: four 18x18, eight 9x9 from operand halves, one 36x36
    for (genvar i = 0; i < LANES; i++) begin : g_p18
        assign p18[i] = $signed(op_a[i]) * $signed(op_b[i]);
    end
    for (genvar j = 0; j < 2*LANES; j++) begin : g_p9
        assign p9[j] = $signed(op_a[j/2][9*(j%2) +: 9]) * $signed(op_b[j/2][9*(j%2) +: 9]);
    end
    assign p36 = $signed({op_a[1], op_a[0]}) * $signed({op_b[1], op_b[0]});
    assign s01 = sub ? 37'(p18[0] - p18[1]) : 37'(p18[0] + p18[1]);
    assign s23 = sub ? 37'(p18[2] - p18[3]) : 37'(p18[2] + p18[3]);
    assign s4 = 38'(s01 + s23);
    assign acc_d = sub ? ACC_W'(acc_q - p18[0]) : ACC_W'(acc_q + p18[0]);

    // Output selection
    always_comb begin
        mux_v = '0;
        if (wid == WID_36) begin
            mux_v = sext(sub ? 72'(-p36) : p36);
        end else begin
            unique case (mode)
                MODE_SIMPLE: begin
                    for (int k = 0; k < 2*LANES; k++) begin
                        if (wid == WID_9) mux_v[18*k +: 18] = p9[k];
                    end
                    if (wid != WID_9) mux_v = {p18[3], p18[2], p18[1], p18[0]};
                end
                MODE_MAC: mux_v = sext(72'(acc_d));
                MODE_SUM2: mux_v = {72'(s23), 72'(s01)};
                MODE_SUM4: mux_v = sext(72'(s4));
            endcase
        end
    end

    // Register path holds one word, so it can take a new one while the old drains
    assign op_ready = reg_on ? (tick && ena && !clr && (!pend_q || f_in_ready)) : f_in_ready;
    assign take = op_valid && op_ready;
    assign f_in_valid = reg_on ? pend_q : op_valid;
    assign f_in_data = reg_on ? out_q : mux_v;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            out_q <= '0;
            pend_q <= 1'b0;
        end else if (reg_on && clr) begin
            out_q <= '0;
            pend_q <= 1'b0;
        end else begin
            if (reg_on && take) out_q <= mux_v;
            if (reg_on && take) pend_q <= 1'b1;
            else if (f_in_ready || !reg_on) pend_q <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn || acc_clr) begin
            acc_q <= '0;
        end else if (take && mode == MODE_MAC && wid != WID_36) begin
            acc_q <= acc_d;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            count_q <= 32'h0000_0000;
        end else if (f_in_valid && f_in_ready) begin
            count_q <= count_q + 32'h0000_0001;
        end
    end

    result_fifo #(.WIDTH(RES_W), .DEPTH(DEPTH)) u_fifo (
        .aclk(aclk),
        .aresetn(aresetn),
        .in_valid(f_in_valid),
        .in_ready(f_in_ready),
        .in_data(f_in_data),
        .out_valid(res_valid),
        .out_ready(res_ready),
        .out_data(res_data),
        .level(f_level)
    );

    sequence cap_s;
        reg_on && take && !clr;
    endsequence
    sequence push_s;
        reg_on && pend_q;
    endsequence

    reg_capture_a: assert property (@(posedge aclk) disable iff (!aresetn)
        cap_s ##1 !clr |-> out_q == $past(mux_v)) else $error("register missed capture");
    reg_clear_a: assert property (@(posedge aclk) disable iff (!aresetn)
        reg_on && clr |=> out_q == '0 && !pend_q) else $error("register not cleared");
    gated_ready_a: assert property (@(posedge aclk) disable iff (!aresetn)
        reg_on && !(tick && ena) |-> !op_ready) else $error("ready without tick and enable");
    any_mode_reg_a: assert property (@(posedge aclk) disable iff (!aresetn)
        cap_s ##1 !clr |-> push_s) else $error("register path not used");
    bypass_pass_a: assert property (@(posedge aclk) disable iff (!aresetn)
        !reg_on && op_valid && mode == MODE_SIMPLE && wid == WID_18 |->
        f_in_valid && f_in_data[35:0] == p18[0]) else $error("simple product not passed");
    nine_lane_a: assert property (@(posedge aclk) disable iff (!aresetn)
        !reg_on && mode == MODE_SIMPLE && wid == WID_9 |->
        f_in_data[143:126] == p9[7]) else $error("9x9 lane wrong");
    sum_four_a: assert property (@(posedge aclk) disable iff (!aresetn)
        !reg_on && mode == MODE_SUM4 && wid == WID_18 |->
        $signed(f_in_data[71:0]) == s4) else $error("sum of four wrong");
    wide_mul_a: assert property (@(posedge aclk) disable iff (!aresetn)
        !reg_on && wid == WID_36 && !sub |-> $signed(f_in_data[71:0]) == p36) else $error("36x36 wrong");
    mac_step_a: assert property (@(posedge aclk) disable iff (!aresetn)
        take && mode == MODE_MAC && wid == WID_18 && !acc_clr |=>
        acc_q == $past(acc_d)) else $error("accumulator did not step");
    mode_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
        !do_write |=> $stable(mode)) else $error("mode changed without write");
endmodule

// ===== src/dsp_out_pkg.sv
// Overview of operation
// - One output multiplexer picks the plain product, the accumulator or the summation result as the block output.
// - The optional output register uses a clock tick, a clear and an enable, each chosen from a set of four.
// - The output register may be switched in or out in every operating mode.
// - The arithmetic stage offers simple multiply, multiply-accumulate, two-product sum and four-product sum.
// - A block holds exactly one mode at a time, and the configuring party never mixes modes in one block.
// - In simple mode each product goes straight out, through or around the output register, unsummed.
// - Simple mode delivers four 18x18 products or eight 9x9 products at once.
// - The block can instead form one 36x36 product, with add or subtract.
package dsp_out_pkg;
    localparam int ADDR_W = 4;
    localparam logic [ADDR_W-1:0] CTRL_OFF = 4'h0;
    localparam logic [ADDR_W-1:0] STATUS_OFF = 4'h4;
    localparam logic [ADDR_W-1:0] COUNT_OFF = 4'h8;
    localparam logic [31:0] CTRL_RST = 32'h0000_0000;
    localparam int MODE_LSB = 0;
    localparam int WID_LSB = 2;
    localparam int REG_ON_BIT = 4;
    localparam int CLK_SEL_LSB = 5;
    localparam int CLR_SEL_LSB = 7;
    localparam int ENA_SEL_LSB = 9;
    localparam int SUB_BIT = 11;
    localparam int ACC_CLR_BIT = 12;
    localparam int CTRL_W = 12;
    localparam int OP_W = 18;
    localparam int LANES = 4;
    localparam int RES_W = 144;
    localparam int ACC_W = 52;
    localparam int FIFO_DEPTH = 32;
    localparam logic [1:0] RESP_OK = 2'b00;
    localparam logic [1:0] RESP_ERR = 2'b10;
    typedef enum logic [1:0] {
        MODE_SIMPLE = 2'b00,
        MODE_MAC = 2'b01,
        MODE_SUM2 = 2'b10,
        MODE_SUM4 = 2'b11
    } mode_t;
    typedef enum logic [1:0] {
        WID_18 = 2'b00,
        WID_9 = 2'b01,
        WID_36 = 2'b10,
        WID_RSV = 2'b11
    } wid_t;
endpackage

// ===== dv/res_sink.sv
`timescale 1ns/1ps
module res_sink
    import dsp_out_pkg::*;
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Stall request from the bench
    input wire logic hold,
    // Result stream
    input wire logic res_valid,
    output logic res_ready,
    input wire logic [RES_W-1:0] res_data,
    // Last word taken
    output logic got,
    output logic [RES_W-1:0] word
);
    // Ready never waits for valid; a stall is the only back-pressure
    assign res_ready = !hold;
    always_ff @(posedge aclk) begin
        got <= aresetn && res_valid && res_ready;
        if (res_valid && res_ready) begin
            word <= res_data;
        end
    end
endmodule

// ===== dv/tb.sv
`timescale 1ns/1ps
module tb;
    import dsp_out_pkg::*;
    logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, op_valid, op_ready, res_valid, res_ready;
    logic hold, got;
    logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
    logic [3:0] s_axi_wstrb, reg_tick, reg_clr, reg_ena;
    logic [31:0] s_axi_wdata, s_axi_rdata, rc;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [LANES-1:0][OP_W-1:0] op_a, op_b;
    logic [RES_W-1:0] res_data, word;
    logic signed [RES_W-1:0] m0;
    logic [31:0] tbl [9];
    int err_total, checks_done, npush;
    dsp_output_stage #(.DEPTH(FIFO_DEPTH)) dsp_output_stage_inst (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .reg_tick, .reg_clr, .reg_ena, .op_valid, .op_ready, .op_a, .op_b, .res_valid,
        .res_ready, .res_data);
    res_sink res_sink_inst (.aclk, .aresetn, .hold, .res_valid, .res_ready, .res_data, .got, .word);
    initial begin
        aclk = 1'h0;
        forever #4 aclk = ~aclk;
    end
    task wrap_up;
        $display("errors %0d checks %0d", err_total, checks_done);
        if (err_total == 0 && checks_done > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic chk(input logic [RES_W-1:0] g, e);
        checks_done++;
        if (g !== e) begin
            err_total++;
            $display("unexpected at %0t: got %h want %h", $time, g, e);
        end
    endtask
    task automatic tmo(input logic ok);
        if (!ok) begin
            err_total++;
            $display("unexpected at %0t: wait ran out", $time);
            wrap_up();
        end
    endtask
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d, input logic [1:0] r);
        int n;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        for (n = 0; n < 50; n++) begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
            if (s_axi_bvalid) break;
        end
        tmo(n < 50);
        s_axi_bready <= 1'h0;
        chk(s_axi_bresp, r);
    endtask
    task automatic rd(input logic [ADDR_W-1:0] a, input logic [31:0] d, input logic [1:0] r);
        int n;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        for (n = 0; n < 50; n++) begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'h0;
            if (s_axi_rvalid) break;
        end
        tmo(n < 50);
        s_axi_rready <= 1'h0;
        chk(s_axi_rresp, r);
        chk(s_axi_rdata, d);
    endtask
    task automatic send;
        int n;
        @(posedge aclk);
        op_valid <= 1'h1;
        for (n = 0; n < 50; n++) begin
            @(posedge aclk);
            if (op_ready) break;
        end
        tmo(n < 50);
        op_valid <= 1'h0;
        npush++;
    endtask
    // Offers an operand and expects it held off; valid drops again so no stray take follows
    task automatic refuse;
        @(posedge aclk);
        op_valid <= 1'h1;
        repeat (3) @(posedge aclk);
        chk(op_ready, 1'h0);
        op_valid <= 1'h0;
    endtask
    task automatic take(input logic [RES_W-1:0] e);
        int n;
        for (n = 0; n < 50; n++) begin
            @(posedge aclk);
            if (got) break;
        end
        tmo(n < 50);
        chk(word, e);
    endtask
    task automatic ctl(input logic [3:0] t, e, c);
        @(posedge aclk);
        reg_tick <= t;
        reg_ena <= e;
        reg_clr <= c;
    endtask
    function automatic logic [31:0] cw(input logic [1:0] m, w, input logic s);
        return (32'(m) << MODE_LSB) | (32'(w) << WID_LSB) | (32'(s) << SUB_BIT);
    endfunction
    function automatic logic [RES_W-1:0] expv(input logic [31:0] c);
        logic signed [RES_W-1:0] p [4];
        logic signed [RES_W-1:0] s01, s23, q;
        logic [RES_W-1:0] r;
        logic [8:0] ha, hb;
        for (int i = 0; i < 4; i++) p[i] = $signed(op_a[i]) * $signed(op_b[i]);
        s01 = c[SUB_BIT] ? p[0] - p[1] : p[0] + p[1];
        s23 = c[SUB_BIT] ? p[2] - p[3] : p[2] + p[3];
        q = $signed({op_a[1], op_a[0]}) * $signed({op_b[1], op_b[0]});
        r = c[SUB_BIT] ? -q : q;
        if (c[WID_LSB+:2] == WID_36) return r;
        case (c[MODE_LSB+:2])
            MODE_SUM2: r = {s23[71:0], s01[71:0]};
            MODE_SUM4: r = s01 + s23;
            default: begin
                r = {p[3][35:0], p[2][35:0], p[1][35:0], p[0][35:0]};
                for (int k = 0; k < 8 && c[WID_LSB+:2] == WID_9; k++) begin
                    ha = k[0] ? op_a[k/2][17:9] : op_a[k/2][8:0];
                    hb = k[0] ? op_b[k/2][17:9] : op_b[k/2][8:0];
                    q = $signed(ha) * $signed(hb);
                    r[18*k+:18] = q[17:0];
                end
            end
        endcase
        return r;
    endfunction
    initial begin
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, op_valid, hold} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, reg_clr} = '0;
        s_axi_wstrb = 4'hF;
        reg_tick = 4'hF;
        reg_ena = 4'hF;
        op_a = {18'h64, 18'h7, 18'h3FFFB, 18'h3};
        op_b = {18'h3E8, 18'h3FFF7, 18'h6, 18'h4};
        m0 = $signed(op_a[0]) * $signed(op_b[0]);
        tbl = '{cw(MODE_SIMPLE, WID_18, 0), cw(MODE_SIMPLE, WID_9, 0), cw(MODE_SIMPLE, WID_RSV, 0),
            cw(MODE_SUM2, WID_18, 0), cw(MODE_SUM2, WID_18, 1), cw(MODE_SUM4, WID_18, 0),
            cw(MODE_SUM4, WID_18, 1), cw(MODE_SUM2, WID_36, 0), cw(MODE_SIMPLE, WID_36, 1)};
        repeat (5) @(posedge aclk);
        aresetn <= 1'h1;
        rd(CTRL_OFF, CTRL_RST, RESP_OK);
        rd(STATUS_OFF, 32'h0, RESP_OK);
        chk(res_valid, 1'h0);
        wr(4'hC, 32'hFFF, RESP_ERR);
        rd(4'hC, 32'h0, RESP_ERR);
        rd(CTRL_OFF, CTRL_RST, RESP_OK);
        foreach (tbl[i]) begin
            wr(CTRL_OFF, tbl[i], RESP_OK);
            rd(CTRL_OFF, tbl[i], RESP_OK);
            send();
            take(expv(tbl[i]));
        end
        wr(CTRL_OFF, cw(MODE_MAC, WID_18, 0), RESP_OK);
        send();
        take(m0);
        send();
        take(m0 + m0);
        wr(CTRL_OFF, cw(MODE_MAC, WID_18, 1), RESP_OK);
        send();
        take(m0);
        wr(CTRL_OFF, cw(MODE_MAC, WID_18, 1) | (32'h1 << ACC_CLR_BIT), RESP_OK);
        send();
        take(-m0);
        // Registered sum4 path; in the accepting setting every unselected control bit is set opposite to the selected one
        rc = cw(MODE_SUM4, WID_18, 0) | (32'h1 << REG_ON_BIT) | (32'h2 << CLK_SEL_LSB) | (32'h3 << CLR_SEL_LSB);
        rc = rc | (32'h1 << ENA_SEL_LSB);
        wr(CTRL_OFF, rc, RESP_OK);
        ctl(4'hB, 4'hF, 4'h7);
        refuse();
        ctl(4'h4, 4'hD, 4'h7);
        refuse();
        ctl(4'h4, 4'h2, 4'hF);
        refuse();
        ctl(4'h4, 4'h2, 4'h7);
        send();
        take(expv(rc));
        ctl(4'hF, 4'hF, 4'h0);
        wr(CTRL_OFF, tbl[1] | (32'h1 << REG_ON_BIT), RESP_OK);
        send();
        take(expv(tbl[1]));
        wr(CTRL_OFF, tbl[0], RESP_OK);
        @(posedge aclk);
        hold <= 1'h1;
        repeat (FIFO_DEPTH) send();
        refuse();
        rd(STATUS_OFF, 32'(FIFO_DEPTH), RESP_OK);
        @(posedge aclk);
        hold <= 1'h0;
        repeat (FIFO_DEPTH) take(expv(tbl[0]));
        rd(STATUS_OFF, 32'h0, RESP_OK);
        rd(COUNT_OFF, 32'(npush), RESP_OK);
        wrap_up();
    end
endmodule
